// file: hw/hbr_pkg.sv
// Package for the half-bridge regulation configuration bank.
// Assumes a register access port supplied by the serial control front end.
package hbr_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int HBR_ADDR_W = 6;
  localparam logic [5:0] HBR_ADDR_OUT13 = 6'h04;
  localparam logic [5:0] HBR_ADDR_OUT46 = 6'h05;
  localparam logic [15:0] HBR_CFG_RESET = 16'h0000;

  // ------------------------------------------------------------------
  // Field layout inside one register
  // ------------------------------------------------------------------
  localparam int HBR_TYPE_HI = 15;
  localparam int HBR_LVL_HI_MSB = 14;
  localparam int HBR_TYPE_MID = 10;
  localparam int HBR_LVL_MID_MSB = 9;
  localparam int HBR_TYPE_LO = 5;
  localparam int HBR_LVL_LO_MSB = 4;
  localparam int HBR_PARITY_BIT = 0;
  localparam int HBR_NUM_OUT = 6;

  // Duty in units of 6.25 percent: code N gives N+1 sixteenths
  localparam logic [4:0] HBR_DUTY_STEP_ONE = 5'h01;

  typedef enum logic {
    HBR_REG_CURRENT = 1'b0,
    HBR_REG_DUTY = 1'b1
  } hbr_reg_type_t;

  // Register port request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } hbr_req_t;

  // Settings applied to one half bridge
  typedef struct packed {
    logic duty_mode;
    logic [4:0] duty_16ths;
    logic [5:0] current_code;
  } hbr_out_cfg_t;

endpackage

// file: hw/hbr_group_map.sv
// Maps stored settings for one group of three outputs to applied settings.
// Assumes group assignment bits come from the grouping register elsewhere.
`timescale 1ns/100ps
module hbr_group_map (
  input wire logic [15:0] i_cfg, // Stored register of three outputs
  input wire logic i_grp_b, // Middle output joins master
  input wire logic i_grp_c, // Top output joins master
  output hbr_pkg::hbr_out_cfg_t o_out [3] // Applied: master, mid, top
);
  import hbr_pkg::*;

  logic [2:0] mode;
  logic [3:0] code [3];
  logic [5:0] sum;

  always_comb begin
    mode[0] = i_cfg[HBR_TYPE_LO];
    mode[1] = i_cfg[HBR_TYPE_MID];
    mode[2] = i_cfg[HBR_TYPE_HI];
    code[0] = i_cfg[HBR_LVL_LO_MSB -: 4];
    code[1] = i_cfg[HBR_LVL_MID_MSB -: 4];
    code[2] = i_cfg[HBR_LVL_HI_MSB -: 4];
    // Grouped current targets add up into the master's total
    sum = {2'b00, code[0]} + (i_grp_b ? {2'b00, code[1]} : 6'h00)
        + (i_grp_c ? {2'b00, code[2]} : 6'h00);
  end

  for (genvar g = 0; g < 3; g++) begin : g_out
    logic member;
    logic eff_mode;
    logic [3:0] eff_code;
    assign member = (g == 1) ? i_grp_b : (g == 2) ? i_grp_c : 1'b0;
    // In duty mode a grouped member follows its master only
    assign eff_mode = (member && mode[0]) ? 1'b1 : mode[g];
    assign eff_code = (member && mode[0]) ? code[0] : code[g];
    assign o_out[g].duty_mode = eff_mode;
    assign o_out[g].duty_16ths = {1'b0, eff_code} + HBR_DUTY_STEP_ONE;
    assign o_out[g].current_code = (g == 0) ? sum :
                                   {2'b00, eff_code};
  end

endmodule

// file: hw/hbr_regulation_cfg.sv
// Regulation configuration bank for the six internal half bridges.
// Assumes the serial front end decodes frames and checks parity, and
// that an actuation timer reports when a timed actuation starts.
//
// Notes on behaviour
// - Register 04H holds outputs 1 to 3, register 05H outputs 4 to 6.
// - The bank decodes address 04H and 05H for those two registers.
// - Both registers are writable and read back their stored value.
// - A write after the start cycle of a timed actuation leaves that actuation unchanged.
// - The latest written settings apply to every later actuation start.
// - In 04H the type bits are bit 15, 10 and 5 for outputs 3, 2, 1.
// - In 04H the level codes are 14:11, 9:6 and 4:1, bit 0 is parity.
// - In 05H the type bits are bit 15, 10 and 5 for outputs 6, 5, 4.
// - In 05H the level codes are 14:11, 9:6 and 4:1, bit 0 is parity.
// - Type 1 selects a duty of (N+1) sixteenths, 6.25 to 100 percent.
// - Type 0 makes the level code a regulated current target.
// - Grouped in duty mode, the master's setting drives every member.
// - Grouped in current mode, member codes add up to the total target.
// - These settings reach only the six internal half bridges.
`timescale 1ns/100ps
module hbr_regulation_cfg (
  input wire logic i_clock, // 100 MHz clock
  input wire logic i_rst, // Asynchronous reset, active high
  input hbr_pkg::hbr_req_t i_req, // Register access request
  input wire logic i_actuating, // Timed actuation in progress
  input wire logic [3:0] i_grp_assign, // Group bits: 2_6,2_5,1_3,1_2
  output logic [15:0] o_rdata, // Read data, parity bit reads zero
  output logic o_rvalid, // Read data valid, one cycle
  output hbr_pkg::hbr_out_cfg_t o_drive [6] // Applied internal settings
);
  import hbr_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg13;
    logic [15:0] cfg46;
    logic [15:0] act13;
    logic [15:0] act46;
    logic [3:0] grp;
    logic act_d;
    logic [15:0] rdata;
    logic rvalid;
  } hbr_state_t;

  hbr_state_t state_reg;
  hbr_state_t state_next;
  hbr_out_cfg_t map_lo [3];
  hbr_out_cfg_t map_hi [3];
  hbr_out_cfg_t drive_next [6];
  hbr_out_cfg_t drive_reg [6];

  function automatic logic [15:0] clean(input logic [15:0] d);
    // Parity is checked upstream and not stored
    clean = {d[15:1], 1'b0};
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.act_d = i_actuating;
    if (i_req.wr && i_req.addr == HBR_ADDR_OUT13) begin
      state_next.cfg13 = clean(i_req.wdata);
    end
    if (i_req.wr && i_req.addr == HBR_ADDR_OUT46) begin
      state_next.cfg46 = clean(i_req.wdata);
    end
    if (i_req.rd) begin
      state_next.rvalid = 1'b1;
      unique case (i_req.addr)
        HBR_ADDR_OUT13: state_next.rdata = state_reg.cfg13;
        HBR_ADDR_OUT46: state_next.rdata = state_reg.cfg46;
        default: state_next.rdata = 16'h0000;
      endcase
    end
    // Applied copy follows storage except while an actuation runs;
    // a write landing in the start cycle still makes this actuation.
    if (!i_actuating || !state_reg.act_d) begin
      state_next.act13 = state_next.cfg13;
      state_next.act46 = state_next.cfg46;
      state_next.grp = i_grp_assign;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '{cfg13: HBR_CFG_RESET, cfg46: HBR_CFG_RESET,
                     act13: HBR_CFG_RESET, act46: HBR_CFG_RESET,
                     grp: 4'h0, act_d: 1'b0, rdata: 16'h0000,
                     rvalid: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Applied settings per internal half bridge
  // ------------------------------------------------------------------
  hbr_group_map u_map_lo (
    .i_cfg(state_next.act13),
    .i_grp_b(state_next.grp[0]),
    .i_grp_c(state_next.grp[1]),
    .o_out(map_lo)
  );

  hbr_group_map u_map_hi (
    .i_cfg(state_next.act46),
    .i_grp_b(state_next.grp[2]),
    .i_grp_c(state_next.grp[3]),
    .o_out(map_hi)
  );

  // Only internal bridges get these; external drivers never modulate
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      drive_next[k] = map_lo[k];
      drive_next[k + 3] = map_hi[k];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < HBR_NUM_OUT; k++) begin
        drive_reg[k] <= '{duty_mode: 1'b0, duty_16ths: 5'h01,
                          current_code: 6'h00};
      end
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign o_drive = drive_reg;
  assign o_rdata = state_reg.rdata;
  assign o_rvalid = state_reg.rvalid;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_wr13_busy;
    i_req.wr && i_req.addr == HBR_ADDR_OUT13 && i_actuating &&
      state_reg.act_d;
  endsequence

  AST_HOLD_DURING_ACT: assert property (@(posedge i_clock) disable iff (i_rst)
    s_wr13_busy |=> $stable(state_reg.act13))
    else $error("Applied 04H changed during actuation");

  AST_APPLY_AFTER: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_actuating |=> state_reg.act13 == state_reg.cfg13 &&
      state_reg.act46 == state_reg.cfg46)
    else $error("Idle applied copy differs from storage");

  AST_WRITE13: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.wr && i_req.addr == HBR_ADDR_OUT13 |=>
      state_reg.cfg13 == {$past(i_req.wdata[15:1]), 1'b0})
    else $error("04H write not stored");

  AST_WRITE46: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.wr && i_req.addr == HBR_ADDR_OUT46 && !i_req.rd ##1 i_req.rd &&
      i_req.addr == HBR_ADDR_OUT46 && !i_req.wr |=>
      o_rvalid && o_rdata == {$past(i_req.wdata[15:1], 2), 1'b0})
    else $error("05H readback mismatch");

  AST_DUTY_STEP: assert property (@(posedge i_clock) disable iff (i_rst)
    o_drive[2].duty_mode |-> o_drive[2].duty_16ths != 5'h00)
    else $error("Duty code out of range");

  AST_OUT3_TYPE: assert property (@(posedge i_clock) disable iff (i_rst)
    !state_next.grp[1] |=> o_drive[2].duty_mode == state_reg.act13[15])
    else $error("Output 3 type bit misplaced");

  AST_OUT5_CODE: assert property (@(posedge i_clock) disable iff (i_rst)
    !state_next.grp[2] && !state_next.act46[10] |=>
      o_drive[4].current_code == {2'b00, state_reg.act46[9:6]})
    else $error("Output 5 level code misplaced");

  AST_GROUP_DUTY: assert property (@(posedge i_clock) disable iff (i_rst)
    state_next.grp[2] && state_next.act46[5] |=>
      o_drive[4].duty_16ths == o_drive[3].duty_16ths)
    else $error("Group member not following master");

  AST_GROUP_SUM: assert property (@(posedge i_clock) disable iff (i_rst)
    state_next.grp[1:0] == 2'b11 |=> o_drive[0].current_code ==
      6'(state_reg.act13[4:1] + state_reg.act13[9:6] +
      state_reg.act13[14:11]))
    else $error("Group current sum wrong");

  AST_RESET_ZERO: assert property (@(posedge i_clock)
    $fell(i_rst) |-> state_reg.cfg13 == 16'h0000 &&
      state_reg.cfg46 == 16'h0000)
    else $error("Registers not zero after reset");

  // ------------------------------------------------------------------
  // Read port checks
  // ------------------------------------------------------------------
  // Every read strobe is answered exactly one cycle later
  AST_RVALID_AFTER_RD: assert property (@(posedge i_clock)
    disable iff (i_rst)
    i_req.rd |=> o_rvalid)
    else $error("Read strobe not answered");

  AST_RVALID_ONLY_RD: assert property (@(posedge i_clock)
    disable iff (i_rst)
    !i_req.rd |=> !o_rvalid)
    else $error("Read valid without a read strobe");

  // A read in the cycle of a write returns the value held before it
  AST_READ13: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.rd && i_req.addr == HBR_ADDR_OUT13 |=>
      o_rdata == $past(state_reg.cfg13))
    else $error("04H read returned wrong data");

  AST_READ_UNMAPPED: assert property (@(posedge i_clock)
    disable iff (i_rst)
    i_req.rd && i_req.addr != HBR_ADDR_OUT13 &&
      i_req.addr != HBR_ADDR_OUT46 |=> o_rdata == 16'h0000)
    else $error("Unmapped address returned data");

  // Parity is never stored, so it can never read back as set
  AST_PARITY_CLEAR: assert property (@(posedge i_clock)
    disable iff (i_rst)
    state_reg.cfg13[0] == 1'b0 && state_reg.cfg46[0] == 1'b0)
    else $error("Parity bit stored");

  // ------------------------------------------------------------------
  // Applied copy checks
  // ------------------------------------------------------------------
  AST_HOLD46: assert property (@(posedge i_clock) disable iff (i_rst)
    i_req.wr && i_req.addr == HBR_ADDR_OUT46 && i_actuating &&
      state_reg.act_d |=> $stable(state_reg.act46))
    else $error("Applied 05H changed during actuation");

  AST_GRP_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    i_actuating && state_reg.act_d |=> $stable(state_reg.grp))
    else $error("Grouping changed during actuation");

  AST_OUT6_TYPE: assert property (@(posedge i_clock) disable iff (i_rst)
    !state_next.grp[3] |=> o_drive[5].duty_mode == state_reg.act46[15])
    else $error("Output 6 type bit misplaced");

  AST_OUT1_DUTY: assert property (@(posedge i_clock) disable iff (i_rst)
    state_next.act13[5] |=> o_drive[0].duty_16ths ==
      5'({1'b0, state_reg.act13[4:1]} + 5'h01))
    else $error("Output 1 duty step wrong");

  AST_OUT2_FOLLOW: assert property (@(posedge i_clock) disable iff (i_rst)
    state_next.grp[0] && state_next.act13[5] |=>
      o_drive[1].duty_16ths == o_drive[0].duty_16ths &&
      o_drive[1].duty_mode)
    else $error("Output 2 not following group master");

endmodule

// file: bench/hbr_host_model.sv
// Host side of the register port: one request per cycle, set at falling edge.
// Assumes the bank answers reads with a one-cycle valid after the strobe.
`timescale 1ns/100ps
module hbr_host_model (
  input wire logic i_clock, // Bench clock
  input wire logic [15:0] i_rdata, // Read data from the bank
  input wire logic i_rvalid, // Read data valid
  output hbr_pkg::hbr_req_t o_req // Request to the bank
);
  import hbr_pkg::*;
  // ----------------------------------------------------------------
  // Request tasks
  // ----------------------------------------------------------------
  initial o_req = '0;
  // A request stands one full cycle, until the next call replaces it
  task automatic put(input logic wr, input logic rd, input logic [5:0] a,
                     input logic [15:0] d);
    @(negedge i_clock);
    o_req <= '{wr: wr, rd: rd, addr: a, wdata: d};
  endtask
  // Idle bus shows inverted leftovers, never the last value
  task automatic idle();
    put(1'b0, 1'b0, ~o_req.addr, ~o_req.wdata);
  endtask
  task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
    put(1'b0, 1'b1, a, ~o_req.wdata);
    idle();
    d = i_rvalid ? i_rdata : 'x;
  endtask
endmodule

// file: bench/hbr_regulation_cfg_tb.sv
// Self-checking bench for the regulation configuration bank.
// Assumes hbr_pkg and the host model are compiled first.
`timescale 1ns/100ps
module hbr_regulation_cfg_tb;
  import hbr_pkg::*;
  logic i_clock, i_rst, i_actuating, o_rvalid;
  logic [3:0] i_grp_assign;
  logic [15:0] o_rdata, rd, r13, r46, w;
  hbr_req_t i_req;
  hbr_out_cfg_t o_drive [6];
  int mismatches, checks_done, seed;
  hbr_regulation_cfg hbr_regulation_cfg_inst (.i_clock(i_clock),
    .i_rst(i_rst), .i_req(i_req), .i_actuating(i_actuating),
    .i_grp_assign(i_grp_assign), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_drive(o_drive));
  hbr_host_model hbr_host_model_inst (.i_clock(i_clock), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid), .o_req(i_req));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  // Ungrouped output: type bit and 4-bit code of its slot
  function automatic hbr_out_cfg_t exp_drive(input int i);
    logic [15:0] r;
    logic [3:0] c;
    r = (i < 3) ? r13 : r46;
    c = r[1 + 5 * (i % 3) +: 4];
    return '{duty_mode: r[5 + 5 * (i % 3)], duty_16ths: {1'b0, c} + 5'h01,
             current_code: {2'b00, c}};
  endfunction
  task automatic check_all();
    for (int i = 0; i < 6; i++) begin
      check(16'(o_drive[i]), 16'(exp_drive(i)));
    end
  endtask
  task automatic give_verdict();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Twenty thousand cycles is far beyond the longest sequence here
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h3fbb;
    mismatches = 0;
    checks_done = 0;
    i_rst = 1'b1;
    i_actuating = 1'b0;
    i_grp_assign = 4'h0;
    r13 = 16'h0000;
    r46 = 16'h0000;
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    check_all();
    hbr_host_model_inst.read_reg(HBR_ADDR_OUT13, rd);
    check(rd, 16'h0000);
    hbr_host_model_inst.read_reg(HBR_ADDR_OUT46, rd);
    check(rd, 16'h0000);
    repeat (20) begin
      r13 = 16'($random(seed));
      r46 = 16'($random(seed));
      hbr_host_model_inst.put(1'b1, 1'b0, HBR_ADDR_OUT13, r13);
      hbr_host_model_inst.put(1'b1, 1'b0, HBR_ADDR_OUT46, r46);
      hbr_host_model_inst.idle();
      r13[0] = 1'b0;
      r46[0] = 1'b0;
      repeat (3) @(negedge i_clock);
      check_all();
      hbr_host_model_inst.read_reg(HBR_ADDR_OUT13, rd);
      check(rd, r13);
      hbr_host_model_inst.read_reg(HBR_ADDR_OUT46, rd);
      check(rd, r46);
    end
    // Read straight after a write with bit 0 set must see bit 0 clear
    hbr_host_model_inst.put(1'b1, 1'b0, HBR_ADDR_OUT46, r46 | 16'h0001);
    hbr_host_model_inst.read_reg(HBR_ADDR_OUT46, rd);
    check(rd, r46);
    hbr_host_model_inst.put(1'b1, 1'b0, 6'h06, 16'hFFFF);
    hbr_host_model_inst.read_reg(6'h06, rd);
    check(rd, 16'h0000);
    hbr_host_model_inst.read_reg(HBR_ADDR_OUT46, rd);
    check(rd, r46);
    // Write during an actuation is stored but not applied until it ends
    i_actuating = 1'b1;
    repeat (2) @(negedge i_clock);
    w = ~r13 & 16'hFFFE;
    hbr_host_model_inst.put(1'b1, 1'b0, HBR_ADDR_OUT13, w);
    hbr_host_model_inst.idle();
    repeat (3) @(negedge i_clock);
    check_all();
    hbr_host_model_inst.read_reg(HBR_ADDR_OUT13, rd);
    check(rd, w);
    i_actuating = 1'b0;
    r13 = w;
    repeat (3) @(negedge i_clock);
    check_all();
    // Grouped duty mode: members follow the master code 3
    i_grp_assign = 4'hF;
    hbr_host_model_inst.put(1'b1, 1'b0, HBR_ADDR_OUT13, 16'hE666);
    hbr_host_model_inst.put(1'b1, 1'b0, HBR_ADDR_OUT46, 16'h7BDE);
    hbr_host_model_inst.idle();
    repeat (3) @(negedge i_clock);
    check({10'h000, o_drive[1].duty_mode, o_drive[1].duty_16ths},
          {11'h001, 5'h04});
    check({10'h000, o_drive[2].duty_mode, o_drive[2].duty_16ths},
          {11'h001, 5'h04});
    // Grouped current mode, all codes 15: the master carries the sum 45
    check({9'h000, o_drive[3].duty_mode, o_drive[3].current_code},
          16'h002D);
    // Group 2 in duty mode, master code 2: members run three sixteenths
    hbr_host_model_inst.put(1'b1, 1'b0, HBR_ADDR_OUT46, 16'h0024);
    hbr_host_model_inst.idle();
    repeat (3) @(negedge i_clock);
    check({10'h000, o_drive[4].duty_mode, o_drive[4].duty_16ths},
          16'h0023);
    check({10'h000, o_drive[5].duty_mode, o_drive[5].duty_16ths},
          16'h0023);
    // Second reset in mid-run clears storage and applied settings
    i_grp_assign = 4'h0;
    i_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    r13 = 16'h0000;
    r46 = 16'h0000;
    @(negedge i_clock);
    check_all();
    hbr_host_model_inst.read_reg(HBR_ADDR_OUT13, rd);
    check(rd, 16'h0000);
    give_verdict();
  end
endmodule
